//--- shared/reader_cmd_consts.vh
// Purpose: constants for the reader command sequencer
// Assumes: 20 MHz system clock
// Notes:   command codes, load layout, crc setup, timing
`ifndef READER_CMD_CONSTS_VH
`define READER_CMD_CONSTS_VH

`define CMD_W          6
`define CMD_IDLE       6'h00
`define CMD_LOADCFG    6'h07
`define CMD_CRC        6'h12
`define CMD_AUTH2      6'h14
`define CMD_RECEIVE    6'h16
`define CMD_TRANSMIT   6'h1A
`define CMD_TRANSCEIVE 6'h1E
`define CMD_POWER_UP_SEQUENCE_CMD    6'h3F

`define EE_AW          16
`define SU_EE_ADDR     16'h0010
`define CFG_REG_BASE   6'h10
`define CFG_LOAD_LAST  6'h1F

`define PAGE_HI        5
`define PAGE_LO        3
`define PAGE_ZERO      3'h0

`define CRC_PRESET     16'h6363
`define CRC_POLY       16'h8408

`define CLK_NS         50
`define BIT_NS         9440

`endif

//--- logic/reader_command_sequencer.v
// Purpose: decodes host command codes and sequences each command
// Assumes: one clock, reset_in covers power-on and reset pin edge
// Notes:   fifo is show-ahead; eeprom answers with ee_ack_in
//
// Functional notes
// (R1) code 14h runs auth phase two, no fifo arguments, no data back
// (R2) code 07h reads two-byte eeprom address, low first, loads registers
// (R3) code 12h runs crc over fifo bytes, returns nothing in fifo
// (R4) crc result low and high bytes held in readable registers
// (R5) transceive behaves as transmit followed by receive
// (R6) power-up command runs automatically after any reset
// (R7) host writes of the power-up code are ignored
// (R8) power-up: async reset of state, then eeprom init load
// (R9) idle command follows power-up completion automatically
// (R10) host must not write during power-up; polls for idle
// (R11) during power-up only page 0 registers may be read
// (R12) host command writes cannot abort power-up
// (R13) code 00h puts block inactive, waiting for next command
// (R14) self-finished command enters idle and pulses done flag
// (R15) host idle write aborts command without done flag
// (R16) abort leaves fifo contents untouched
// (R17) new command code cancels running command except power-up
// (R18) code 1Eh transmits then enables receiver after rx wait time
// (R19) command write decoded, command begins on following cycle
`timescale 1ns/1ns
`default_nettype none
`include "reader_cmd_consts.vh"

module reader_command_sequencer (
   input  wire                clk_in,
   input  wire                reset_in,
   input  wire                cmd_wr_in,
   input  wire [`CMD_W-1:0]   cmd_code_in,
   output wire [`CMD_W-1:0]   cmd_reg_out,
   input  wire                host_rd_in,
   input  wire [5:0]          host_rd_addr_in,
   output wire                rd_grant_out,
   input  wire                fifo_empty_in,
   input  wire [7:0]          fifo_data_in,
   output wire                fifo_pop_out,
   output wire                ee_rd_out,
   output wire [`EE_AW-1:0]   ee_addr_out,
   input  wire                ee_ack_in,
   input  wire [7:0]          ee_data_in,
   output wire                cfg_wr_out,
   output wire [5:0]          cfg_addr_out,
   output wire [7:0]          cfg_data_out,
   output wire [7:0]          crc_result_low_out,
   output wire [7:0]          crc_result_high_out,
   output wire                auth_phase_two_cmd_out,
   input  wire                auth_done_in,
   output wire                tx_active_out,
   input  wire                tx_done_in,
   input  wire [7:0]          rx_wait_in,
   output wire                rx_active_out,
   input  wire                rx_done_in,
   output wire                command_done_flag_out
);

   localparam [8:0] S_IDLE = 9'h001;
   localparam [8:0] S_ALO  = 9'h002;
   localparam [8:0] S_AHI  = 9'h004;
   localparam [8:0] S_LOAD = 9'h008;
   localparam [8:0] S_CRC  = 9'h010;
   localparam [8:0] S_AUTH = 9'h020;
   localparam [8:0] S_TX   = 9'h040;
   localparam [8:0] S_RXW  = 9'h080;
   localparam [8:0] S_RX   = 9'h100;

   localparam integer BIT_CYC_I = `BIT_NS / `CLK_NS;
   localparam [7:0]   BIT_CYC   = BIT_CYC_I[7:0];

   reg [8:0]          state_q;
   reg [`CMD_W-1:0]   cmd_q;
   reg [`CMD_W-1:0]   wr_code_q;
   reg                wr_pend_q;
   reg [`EE_AW-1:0]   ee_addr_q;
   reg                ee_rd_q;
   reg [5:0]          cnt_q;
   reg [5:0]          reg_idx_q;
   reg                cfg_wr_q;
   reg [5:0]          cfg_addr_q;
   reg [7:0]          cfg_data_q;
   reg [15:0]         crc_q;
   reg [7:0]          crc_lo_q;
   reg [7:0]          crc_hi_q;
   reg [7:0]          rxw_q;
   reg [7:0]          div_q;
   reg                done_q;

   wire power_up_sequence_cmd_w = (cmd_q == `CMD_POWER_UP_SEQUENCE_CMD);
   wire bit_tick  = (div_q == BIT_CYC - 8'h01);

   function [15:0] crc_byte;
      input [15:0] c;
      input [7:0]  d;
      integer      i;
      reg   [15:0] x;
      begin
         x = c ^ {8'h00, d};
         for (i = 0; i < 8; i = i + 1) begin
            if (x[0])
               x = {1'b0, x[15:1]} ^ `CRC_POLY;
            else
               x = {1'b0, x[15:1]};
         end
         crc_byte = x;
      end
   endfunction

   // page 0 reads only while powering up
   assign rd_grant_out = host_rd_in & (~power_up_sequence_cmd_w |
      (host_rd_addr_in[`PAGE_HI:`PAGE_LO] == `PAGE_ZERO));          // [R11]
   // fifo only drained by argument and crc states
   assign fifo_pop_out = ~fifo_empty_in & ~wr_pend_q &
      (state_q[1] | state_q[2] | state_q[4]);                       // [R16]

   assign cmd_reg_out            = cmd_q;
   assign ee_rd_out              = ee_rd_q;
   assign ee_addr_out            = ee_addr_q;
   assign cfg_wr_out             = cfg_wr_q;
   assign cfg_addr_out           = cfg_addr_q;
   assign cfg_data_out           = cfg_data_q;
   assign crc_result_low_out     = crc_lo_q;
   assign crc_result_high_out    = crc_hi_q;
   assign auth_phase_two_cmd_out = state_q[5] & ~wr_pend_q;
   assign tx_active_out          = state_q[6] & ~wr_pend_q;
   assign rx_active_out          = state_q[8] & ~wr_pend_q;
   assign command_done_flag_out  = done_q;

   // bit-rate enable divider
   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in)
         div_q <= 8'h00;
      else if (bit_tick)
         div_q <= 8'h00;
      else
         div_q <= div_q + 8'h01;
   end

   // host command capture, never during power-up
   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         wr_pend_q <= 1'b0;
         wr_code_q <= `CMD_IDLE;
      end else if (cmd_wr_in & ~power_up_sequence_cmd_w &
                   (cmd_code_in != `CMD_POWER_UP_SEQUENCE_CMD)) begin      // [R7] [R12]
         wr_pend_q <= 1'b1;                                  // [R19]
         wr_code_q <= cmd_code_in;
      end else begin
         wr_pend_q <= 1'b0;
      end
   end

   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         state_q    <= S_LOAD;                               // [R6] [R8]
         cmd_q      <= `CMD_POWER_UP_SEQUENCE_CMD;
         ee_addr_q  <= `SU_EE_ADDR;
         ee_rd_q    <= 1'b0;
         cnt_q      <= 6'h00;
         reg_idx_q  <= `CFG_REG_BASE;
         cfg_wr_q   <= 1'b0;
         cfg_addr_q <= 6'h00;
         cfg_data_q <= 8'h00;
         crc_q      <= `CRC_PRESET;
         crc_lo_q   <= 8'h00;
         crc_hi_q   <= 8'h00;
         rxw_q      <= 8'h00;
         done_q     <= 1'b0;
      end else begin
         done_q   <= 1'b0;
         cfg_wr_q <= 1'b0;
         if (wr_pend_q) begin
            // new code cancels current work, no done flag
            cmd_q   <= wr_code_q;                            // [R17] [R15]
            ee_rd_q <= 1'b0;
            case (wr_code_q)
               `CMD_LOADCFG: begin
                  state_q <= S_ALO;                          // [R2]
               end
               `CMD_CRC: begin
                  state_q <= S_CRC;                          // [R3]
                  crc_q   <= `CRC_PRESET;
               end
               `CMD_AUTH2: begin
                  state_q <= S_AUTH;                         // [R1]
               end
               `CMD_TRANSMIT, `CMD_TRANSCEIVE: begin
                  state_q <= S_TX;                           // [R5] [R18]
               end
               `CMD_RECEIVE: begin
                  state_q <= S_RXW;
                  rxw_q   <= rx_wait_in;
               end
               default: begin
                  state_q <= S_IDLE;                         // [R13]
                  cmd_q   <= `CMD_IDLE;
               end
            endcase
         end else begin
            case (state_q)
               S_ALO: begin
                  if (~fifo_empty_in) begin
                     ee_addr_q[7:0] <= fifo_data_in;         // [R2]
                     state_q        <= S_AHI;
                  end
               end
               S_AHI: begin
                  if (~fifo_empty_in) begin
                     ee_addr_q[15:8] <= fifo_data_in;        // [R2]
                     cnt_q           <= 6'h00;
                     reg_idx_q       <= `CFG_REG_BASE;
                     state_q         <= S_LOAD;
                  end
               end
               S_LOAD: begin
                  if (~ee_rd_q) begin
                     ee_rd_q <= 1'b1;
                  end else if (ee_ack_in) begin
                     ee_rd_q    <= 1'b0;
                     cfg_wr_q   <= 1'b1;                     // [R8] [R2]
                     cfg_addr_q <= reg_idx_q;
                     cfg_data_q <= ee_data_in;
                     reg_idx_q  <= reg_idx_q + 6'h01;
                     ee_addr_q  <= ee_addr_q + 16'h0001;
                     cnt_q      <= cnt_q + 6'h01;
                     if (cnt_q == `CFG_LOAD_LAST) begin
                        state_q <= S_IDLE;                   // [R9] [R14]
                        cmd_q   <= `CMD_IDLE;
                        done_q  <= 1'b1;
                     end
                  end
               end
               S_CRC: begin
                  if (~fifo_empty_in) begin
                     crc_q <= crc_byte(crc_q, fifo_data_in); // [R3]
                  end else begin
                     crc_lo_q <= crc_q[7:0];                 // [R4]
                     crc_hi_q <= crc_q[15:8];
                     state_q  <= S_IDLE;                     // [R14]
                     cmd_q    <= `CMD_IDLE;
                     done_q   <= 1'b1;
                  end
               end
               S_AUTH: begin
                  if (auth_done_in) begin
                     state_q <= S_IDLE;                      // [R1] [R14]
                     cmd_q   <= `CMD_IDLE;
                     done_q  <= 1'b1;
                  end
               end
               S_TX: begin
                  if (tx_done_in) begin
                     if (cmd_q == `CMD_TRANSCEIVE) begin
                        state_q <= S_RXW;                    // [R5] [R18]
                        rxw_q   <= rx_wait_in;
                     end else begin
                        state_q <= S_IDLE;                   // [R14]
                        cmd_q   <= `CMD_IDLE;
                        done_q  <= 1'b1;
                     end
                  end
               end
               S_RXW: begin
                  if (rxw_q == 8'h00)
                     state_q <= S_RX;                        // [R18]
                  else if (bit_tick)
                     rxw_q <= rxw_q - 8'h01;
               end
               S_RX: begin
                  if (rx_done_in) begin
                     state_q <= S_IDLE;                      // [R14]
                     cmd_q   <= `CMD_IDLE;
                     done_q  <= 1'b1;
                  end
               end
               default: begin
                  state_q <= S_IDLE;                         // [R13]
               end
            endcase
         end
      end
   end

endmodule

`default_nettype wire

//--- tb/seq_props.sv
// Purpose: port assertions for the command sequencer
// Assumes: single clk_in domain, reset_in async active high
// Notes:   bound into every sequencer instance
`timescale 1ns/1ns
`default_nettype none
module seq_props (
   input wire logic        clk_in,
   input wire logic        reset_in,
   input wire logic        cmd_wr_in,
   input wire logic        host_rd_in,
   input wire logic [5:0]  cmd_code_in,
   input wire logic [5:0]  cmd_reg_out,
   input wire logic [5:0]  host_rd_addr_in,
   input wire logic        rd_grant_out,
   input wire logic        fifo_pop_out,
   input wire logic        ee_rd_out,
   input wire logic [15:0] ee_addr_out,
   input wire logic [7:0]  ee_data_in,
   input wire logic [7:0]  cfg_data_out,
   input wire logic        ee_ack_in,
   input wire logic        cfg_wr_out,
   input wire logic        command_done_flag_out,
   input wire logic        auth_phase_two_cmd_out,
   input wire logic        auth_done_in,
   input wire logic        tx_active_out,
   input wire logic        rx_active_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   sequence take_s;
      cmd_wr_in && cmd_reg_out != 6'h3F &&
      cmd_code_in inside {6'h07, 6'h14, 6'h1A, 6'h1E} ##1 !cmd_wr_in;
   endsequence
   sequence abort_s;
      cmd_wr_in && cmd_code_in == 6'h00 && cmd_reg_out == 6'h14
      ##1 !auth_done_in;
   endsequence
   grant_page_a: assert property (
      rd_grant_out == (host_rd_in &&
      (cmd_reg_out != 6'h3F || host_rd_addr_in[5:3] == 3'h0)))
      else $error("read grant wrong");
   power_up_exit_a: assert property (
      cmd_reg_out == 6'h3F |=> cmd_reg_out inside {6'h3F, 6'h00})
      else $error("power-up left wrongly");
   no_restart_a: assert property (
      cmd_reg_out != 6'h3F |=> cmd_reg_out != 6'h3F)
      else $error("power-up restarted");
   load_on_ack_a: assert property (
      ee_rd_out && ee_ack_in && !$past(cmd_wr_in) |=> cfg_wr_out &&
      !ee_rd_out && cfg_data_out == $past(ee_data_in))
      else $error("register load missing");
   read_held_a: assert property (
      cmd_reg_out == 6'h3F && ee_rd_out && !ee_ack_in |=>
      ee_rd_out && $stable(ee_addr_out))
      else $error("eeprom read dropped");
   done_idle_a: assert property (
      command_done_flag_out |-> cmd_reg_out == 6'h00
      ##1 !command_done_flag_out)
      else $error("done pulse wrong");
   take_show_a: assert property (
      take_s |-> ##1 cmd_reg_out == $past(cmd_code_in, 2))
      else $error("command not started");
   abort_quiet_a: assert property (
      abort_s |-> ##1 (cmd_reg_out == 6'h00 && !command_done_flag_out)[*2])
      else $error("abort flagged done");
   idle_no_pop_a: assert property (
      cmd_reg_out == 6'h00 |-> !fifo_pop_out)
      else $error("idle popped fifo");
   tx_before_rx_a: assert property (
      tx_active_out |-> !rx_active_out &&
      cmd_reg_out inside {6'h1A, 6'h1E})
      else $error("tx and rx overlap");
   auth_level_a: assert property (
      auth_phase_two_cmd_out |-> cmd_reg_out == 6'h14 && !fifo_pop_out)
      else $error("auth level wrong");
endmodule
bind reader_command_sequencer seq_props props_u (.*);
`default_nettype wire

//--- tb/ee_model.sv
// Purpose: eeprom responder on the sequencer read port
// Assumes: one read outstanding, ack is a one-cycle pulse
// Notes:   slow_in adds three wait cycles per byte
`timescale 1ns/1ns
`default_nettype none
module ee_model (
   input  wire logic        clk_in,
   input  wire logic        reset_in,
   input  wire logic        ee_rd_in,
   input  wire logic [15:0] ee_addr_in,
   input  wire logic        slow_in,
   output var  logic        ee_ack_out,
   output var  logic [7:0]  ee_data_out
);
   int n = 0;
   initial {ee_ack_out, ee_data_out} = 9'h000;
   // data line shows the inverse once released
   always @(posedge clk_in) begin
      #2;
      if (ee_ack_out || reset_in) begin
         ee_ack_out = 1'b0;
         ee_data_out = ~ee_data_out;
         n = 0;
      end else if (ee_rd_in && n >= (slow_in ? 3 : 0)) begin
         ee_ack_out = 1'b1;
         ee_data_out = ee_addr_in[7:0] ^ 8'h5A;
      end else if (ee_rd_in) n++;
   end
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Purpose: self-checking bench for the command sequencer
// Assumes: 20 MHz clock, inputs driven 2 ns after rising edge
// Notes:   fifo and host modelled here, eeprom in ee_model
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic clk_in = 0, reset_in = 1, cmd_wr_in = 0, host_rd_in = 0, slow = 0;
   logic fifo_empty_in = 1, auth_done_in = 0, tx_done_in = 0;
   logic rx_done_in = 0, pop_s = 0, rd_grant_out, fifo_pop_out, ee_rd_out;
   logic ee_ack_in, cfg_wr_out, auth_phase_two_cmd_out, tx_active_out;
   logic rx_active_out, command_done_flag_out;
   logic [5:0] cmd_code_in = 0, host_rd_addr_in = 0, cmd_reg_out;
   logic [5:0] cfg_addr_out;
   logic [7:0] fifo_data_in = 0, rx_wait_in = 8'h02, ee_data_in;
   logic [7:0] cfg_data_out, crc_result_low_out, crc_result_high_out;
   logic [15:0] ee_addr_out, exp;
   logic [15:0] xa, ee_base = 16'h0010;
   logic [13:0] xc;
   logic [31:0] rnd = 32'h5cfe;
   logic [7:0] q[$];
   int n_fail = 0, total_checks = 0, n_cfg = 0, n_done = 0, k, d0;
   reader_command_sequencer dut_u (.*);
   ee_model ee_u (.clk_in(clk_in), .reset_in(reset_in),
      .ee_rd_in(ee_rd_out), .ee_addr_in(ee_addr_out), .slow_in(slow),
      .ee_ack_out(ee_ack_in), .ee_data_out(ee_data_in));
   always #25 clk_in = ~clk_in;
   function logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function logic [15:0] crc_of(input int n);
      logic [15:0] c;
      c = 16'h6363;
      for (int i = 0; i < n; i++) begin
         c = c ^ q[i];
         for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
      end
      return c;
   endfunction
   // show-ahead fifo, pops sampled mid-cycle
   always @(negedge clk_in) begin
      pop_s = fifo_pop_out;
      if (command_done_flag_out === 1'b1) n_done++;
      if (cfg_wr_out === 1'b1) begin
         // register index and eeprom byte per load step
         xa = ee_base + 16'(n_cfg % 32);
         xc = {6'h10 + 6'(n_cfg % 32), xa[7:0] ^ 8'h5A};
         chk({cfg_addr_out, cfg_data_out} === xc, "cfg load");
         n_cfg++;
      end
   end
   always @(posedge clk_in) begin
      #2;
      if (pop_s && q.size() > 0) void'(q.pop_front());
      fifo_empty_in = (q.size() == 0);
      fifo_data_in = fifo_empty_in ? ~fifo_data_in : q[0];
   end
   task test_done;
      $display("checks %0d, failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input logic ok, input string m);
      total_checks++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask
   task step(input int n);
      repeat (n) @(posedge clk_in);
      #2;
   endtask
   task timeout_if(input logic hit);
      if (hit) begin
         chk(1'b0, "wait timed out");
         test_done;
      end
   endtask
   task wr(input logic [5:0] c);
      step(1);
      cmd_wr_in = 1;
      cmd_code_in = c;
      step(1);
      cmd_wr_in = 0;
      cmd_code_in = ~c;
   endtask
   task wait_idle(input int lim);
      step(1);
      for (k = 0; cmd_reg_out !== 6'h00; k++) begin
         timeout_if(k == lim);
         step(1);
      end
      step(1);
   endtask
   initial begin
      step(5);
      reset_in = 0;
      host_rd_in = 1;
      host_rd_addr_in = 6'h08;
      step(1);
      chk(rd_grant_out === 1'b0, "page 1 read in power-up");
      host_rd_addr_in = 6'h02;
      wr(6'h1A);
      chk(rd_grant_out === 1'b1, "page 0 read refused");
      step(2);
      chk(cmd_reg_out === 6'h3F, "power-up aborted");
      wait_idle(400);
      chk(n_cfg === 32 && n_done === 1, "power-up load");
      wr(6'h3F);
      wr(6'h0C);
      step(3);
      chk(cmd_reg_out === 6'h00 && n_done === 1, "3F or 0C ran");
      for (int t = 0; t < 4; t++) begin
         for (int i = 0; i < t; i++) begin
            rnd = lfsr(rnd);
            q.push_back(rnd[7:0]);
         end
         exp = crc_of(t);
         d0 = n_done;
         wr(6'h12);
         wait_idle(100);
         chk({crc_result_high_out, crc_result_low_out} === exp, "crc");
         chk(q.size() === 0 && n_done === d0 + 1, "crc end");
      end
      slow = 1;
      rnd = lfsr(rnd);
      q.push_back(rnd[7:0]);
      q.push_back(rnd[15:8]);
      ee_base = rnd[15:0];
      d0 = n_cfg;
      wr(6'h07);
      for (k = 0; ee_rd_out !== 1'b1; k++) begin
         timeout_if(k == 50);
         step(1);
      end
      chk(ee_addr_out === rnd[15:0], "load address order");
      wait_idle(400);
      chk(n_cfg === d0 + 32 && q.size() === 0, "load count");
      q.push_back(8'hA5);
      q.push_back(8'h5A);
      d0 = n_done;
      wr(6'h14);
      step(4);
      chk(auth_phase_two_cmd_out === 1'b1 && q.size() === 2, "auth");
      wr(6'h00);
      step(4);
      chk(n_done === d0 && q.size() === 2, "abort");
      wr(6'h14);
      wr(6'h1A);
      step(2);
      chk(cmd_reg_out === 6'h1A && auth_phase_two_cmd_out === 1'b0, "cancel");
      wr(6'h00);
      q.delete();
      wr(6'h14);
      step(4);
      auth_done_in = 1;
      step(1);
      auth_done_in = 0;
      wait_idle(20);
      chk(n_done === d0 + 1, "auth done");
      q.push_back(rnd[23:16]);
      wr(6'h1E);
      step(3);
      chk(tx_active_out === 1'b1 && rx_active_out === 1'b0, "tx");
      tx_done_in = 1;
      step(1);
      tx_done_in = 0;
      for (k = 0; rx_active_out !== 1'b1; k++) begin
         timeout_if(k == 600);
         step(1);
      end
      chk(k >= 190 && k <= 377 && cmd_reg_out === 6'h1E, "rx wait");
      rx_done_in = 1;
      step(1);
      rx_done_in = 0;
      wait_idle(20);
      chk(n_done === d0 + 2, "transceive end");
      // receive with no wait, then a plain transmit
      rx_wait_in = 8'h00;
      wr(6'h16);
      step(2);
      chk(rx_active_out === 1'b1 && cmd_reg_out === 6'h16, "rx no wait");
      rx_done_in = 1;
      step(1);
      rx_done_in = 0;
      wr(6'h1A);
      step(2);
      chk(tx_active_out === 1'b1 && n_done === d0 + 3, "receive end");
      tx_done_in = 1;
      step(1);
      tx_done_in = 0;
      wait_idle(20);
      chk(n_done === d0 + 4 && rx_active_out === 1'b0, "tx end");
      // mid-run reset, slow eeprom this time
      ee_base = 16'h0010;
      reset_in = 1;
      step(2);
      reset_in = 0;
      chk(cmd_reg_out === 6'h3F && ee_rd_out === 1'b0, "reset state");
      wait_idle(400);
      chk(n_cfg === 96 && n_done === d0 + 5, "power-up again");
      test_done;
   end
endmodule
`default_nettype wire
